//--- verification/rdc_link_sva.sv
// interface watcher for the converter-to-host readout link
`default_nettype none
module rdc_link_sva (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sample_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic pos_vel_select,
  input wire logic serial_port_select_n,
  input wire logic full_reset_n,
  input wire logic [11:0] dev_bus,
  input wire logic [11:0] dev_bus_oe,
  input wire logic signal_degraded_flag_n,
  input wire logic tracking_lost_flag_n
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] lo_ff;
  logic [7:0] hi_ff;

  // ============================================================
  // capture strobe run lengths, saturating so long idles never wrap
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      lo_ff <= 8'h00;
      hi_ff <= 8'h00;
    end else begin
      lo_ff <= sample_n ? 8'h00 : lo_ff + {7'h00, lo_ff != 8'hff};
      hi_ff <= !sample_n ? 8'h00 : hi_ff + {7'h00, hi_ff != 8'hff};
    end
  end

  // ============================================================
  // pin drivers follow the filtered strobes (three edges plus a register)
  a_bus_float_idle: assert property (rd_n [*6] |-> dev_bus_oe == 12'h000)
    else $error("bus driven while read strobe high");
  a_serial_low_float: assert property (!serial_port_select_n [*6]
    |-> dev_bus_oe[10:0] == 11'h000)
    else $error("low bits driven in serial mode");
  a_parallel_drive: assert property ((!cs_n && !rd_n && serial_port_select_n) [*6]
    |-> dev_bus_oe == 12'hfff)
    else $error("parallel bus not driven during read");
  a_serial_so_drive: assert property ((!cs_n && !rd_n && !serial_port_select_n) [*6]
    |-> dev_bus_oe == 12'h800)
    else $error("serial output not driven during read");
  a_buffer_hold: assert property ((dev_bus_oe == 12'hfff && $past(dev_bus_oe) == 12'hfff)
    |-> $stable(dev_bus))
    else $error("parallel word changed during one read");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> dev_bus_oe == 12'h000
    && signal_degraded_flag_n && tracking_lost_flag_n)
    else $error("pins not idle out of reset");
  // host side strobe timing
  a_capture_width: assert property ($rose(sample_n) |-> lo_ff >= 8'd33)
    else $error("capture pulse too short");
  a_read_after_capture: assert property ($fell(rd_n) |-> sample_n && hi_ff >= 8'd94)
    else $error("read strobe too soon after capture");
  a_select_setup: assert property ($fell(rd_n) |-> !cs_n
    && $stable(pos_vel_select) && pos_vel_select == $past(pos_vel_select, 2))
    else $error("select moved near read strobe");
  a_reset_pulse: assert property ($fell(full_reset_n) |-> !full_reset_n [*8])
    else $error("tracking reset pulse too short");

  c_parallel: cover property ($fell(rd_n) && serial_port_select_n);
  c_serial: cover property ($fell(rd_n) && !serial_port_select_n);
  c_loss: cover property (!signal_degraded_flag_n && !tracking_lost_flag_n);
endmodule
`default_nettype wire

//--- verification/resolver_position_velocity_readout_tb.sv
// self-checking bench joining converter and host across the pin link
`include "rdc_defs.svh"
`default_nettype none
module resolver_position_velocity_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, shaft_angle, monitor_mag, step_amt, position;
  logic [31:0] pwdata, prdata;
  int fail_count, total_checks, cyc;

  rdc_link_if link();
  rdc_device i_rdc_device (.core_clk_i(core_clk), .rst_b_i(rst_b), .shaft_angle_i(shaft_angle),
    .monitor_mag_i(monitor_mag), .position_o(position), .link(link));
  rdc_host i_rdc_host (.core_clk_i(core_clk), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link));
  rdc_link_sva i_rdc_link_sva (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .sample_n(link.sample_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .pos_vel_select(link.pos_vel_select), .serial_port_select_n(link.serial_port_select_n),
    .full_reset_n(link.full_reset_n), .dev_bus(link.dev_bus), .dev_bus_oe(link.dev_bus_oe),
    .signal_degraded_flag_n(link.signal_degraded_flag_n),
    .tracking_lost_flag_n(link.tracking_lost_flag_n));

  // ============================================================
  // clock, shaft motion and hang guard
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    shaft_angle <= shaft_angle + step_amt;
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      stop_test();
    end
  end

  // ============================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait limit here: only the cycle guard may end a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start a capture and read, wait out busy, fetch the word
  task automatic link_read(input logic [3:0] c, output logic [15:0] w);
    logic [31:0] r;
    logic e;
    apb(1'b1, `RDC_CTRL_OFS, {28'h0, c}, r, e);
    do begin
      apb(1'b0, `RDC_STATUS_OFS, 32'h0, r, e);
    end while (r[0] !== 1'b0);
    apb(1'b0, `RDC_DATA_OFS, 32'h0, r, e);
    w = r[15:0];
  endtask
  task automatic flags(input logic [1:0] exp);
    check({link.signal_degraded_flag_n, link.tracking_lost_flag_n}, exp);
  endtask

  // ============================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, `RDC_CTRL_OFS, 32'h0, r, e);
    check(r, 32'h2);
    apb(1'b0, `RDC_STATUS_OFS, 32'h0, r, e);
    check(r, 32'h26);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    $display("register test done");
  endtask
  task automatic t_motion();
    logic [15:0] w;
    logic [11:0] d;
    step_amt <= 12'h001;
    repeat (20) @(posedge core_clk);
    link_read(4'h1, w);
    check(w[11:0], 12'h001);
    step_amt <= 12'hfff;
    repeat (20) @(posedge core_clk);
    link_read(4'h1, w);
    check(w[11:0], 12'hfff);
    // one-cycle jump through the step, so the angle has a single driver
    step_amt <= 12'h5a3;
    @(posedge core_clk);
    step_amt <= 12'h000;
    repeat (3000) @(posedge core_clk);
    d = position - shaft_angle + 12'h001;
    check(d <= 12'h002, 1'b1);
    link_read(4'h3, w);
    d = w[11:0] - shaft_angle + 12'h001;
    check(d <= 12'h002, 1'b1);
    link_read(4'h7, w);
    check({w[3:1], ^w}, 4'hf);
    link_read(4'h5, w);
    check(w, 16'h0007);
    $display("motion test done");
  endtask
  task automatic t_faults();
    logic [31:0] r;
    logic [15:0] w;
    logic [11:0] d;
    logic e;
    // loss latches both flags; restoring the signal must not release them
    monitor_mag <= 12'h050;
    repeat (20) @(posedge core_clk);
    monitor_mag <= 12'h800;
    repeat (20) @(posedge core_clk);
    flags(2'b00);
    // flags still latched, yet the angle must be the live one
    link_read(4'h3, w);
    d = w[11:0] - shaft_angle + 12'h001;
    check(d <= 12'h002, 1'b1);
    flags(2'b11);
    apb(1'b0, `RDC_STATUS_OFS, 32'h0, r, e);
    check(r[5:3], 3'b011);
    apb(1'b1, `RDC_STATUS_OFS, 32'h18, r, e);
    apb(1'b0, `RDC_STATUS_OFS, 32'h0, r, e);
    check(r[5:1], 5'b10011);
    // over-range, then a min/max spread that stays latched until capture rise
    monitor_mag <= 12'hf80;
    repeat (20) @(posedge core_clk);
    flags(2'b01);
    monitor_mag <= 12'h800;
    link_read(4'h1, w);
    flags(2'b11);
    monitor_mag <= 12'h700;
    repeat (10) @(posedge core_clk);
    monitor_mag <= 12'h950;
    repeat (10) @(posedge core_clk);
    monitor_mag <= 12'h800;
    repeat (20) @(posedge core_clk);
    flags(2'b01);
    link_read(4'h1, w);
    flags(2'b11);
    apb(1'b0, `RDC_STATUS_OFS, 32'h0, r, e);
    check(r[4], 1'b0);
    // tracking reset puts the loop far from the shaft: tracking flag only
    apb(1'b1, `RDC_CTRL_OFS, 32'ha, r, e);
    repeat (30) @(posedge core_clk);
    flags(2'b10);
    $display("fault test done");
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    shaft_angle = 12'h000;
    step_amt = 12'h000;
    monitor_mag = 12'h800;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_motion();
    t_faults();
    stop_test();
  end
endmodule
`default_nettype wire

//--- verilog/rdc_defs.svh
// shared offsets, field positions, reset values and timing counts
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

// ============================================================
// clock and pin timing
`define RDC_CLK_NS 8
`define RDC_TCK_NS 122
`define RDC_T1_NS (2 * `RDC_TCK_NS + 20)
`define RDC_T1_CYC ((`RDC_T1_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`define RDC_T2_NS (6 * `RDC_TCK_NS + 20)
`define RDC_T2_CYC ((`RDC_T2_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`define RDC_T3_NS 18
`define RDC_T3_CYC ((`RDC_T3_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`define RDC_T4_NS 5
`define RDC_T4_CYC ((`RDC_T4_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`define RDC_SCLK_NS 40
`define RDC_SYNC_CYC 4
`define RDC_SCLK_HALF_CYC \
  ((`RDC_SCLK_NS / 2 + `RDC_CLK_NS - 1) / `RDC_CLK_NS + `RDC_SYNC_CYC)
`define RDC_RD_WAIT_CYC (`RDC_T3_CYC + `RDC_SYNC_CYC + 2)
`define RDC_DEV_RST_CYC 16

// ============================================================
// device pin indices inside the synchroniser vectors
`define RDC_PIN_SAMPLE 0
`define RDC_PIN_CS 1
`define RDC_PIN_RD 2
`define RDC_PIN_PVSEL 3
`define RDC_PIN_SERSEL 4
`define RDC_PIN_SCLK 5
`define RDC_PIN_RESET 6
`define RDC_PINS 7
`define RDC_BIT_TEN 10
`define RDC_BIT_ELEVEN 11

// ============================================================
// serial word layout and fault thresholds
`define RDC_SW_PVSEL 3
`define RDC_SW_DEGR 2
`define RDC_SW_TRK 1
`define RDC_SW_PAR 0
`define RDC_LOSS_MIN 12'h100
`define RDC_DEGR_MAX 12'hf00
`define RDC_DEGR_MISM 12'h200
`define RDC_TRK_SET 12'h039
`define RDC_TRK_CLR 12'h00b
`define RDC_MON_MIN_RST 12'hfff
`define RDC_HALF_TURN 12'h800

// ============================================================
// controller registers
`define RDC_CTRL_OFS 12'h000
`define RDC_STATUS_OFS 12'h004
`define RDC_DATA_OFS 12'h008
`define RDC_CTRL_GO 0
`define RDC_CTRL_PVSEL 1
`define RDC_CTRL_SERIAL 2
`define RDC_CTRL_RESET 3
`define RDC_CTRL_RST 4'h2
`define RDC_ST_BUSY 0
`define RDC_ST_DEGR_N 1
`define RDC_ST_TRK_N 2
`define RDC_ST_FAULT 3
`define RDC_ST_RESTART 4
`define RDC_ST_VALID 5

`endif

//--- verilog/rdc_device.sv
// resolver converter readout end: tracking loop, holding regs, fault flags, ports
// Operation
// - host treats data after any fault invalid
// - faults never force outputs to fixed values
// - host restarts only after signal-loss fault
// - tracking error moves one LSB every clock
// - half-turn null escapes within one clock
// - host fully resets device after signal loss
// - select pin high gives parallel data bus
// - select low: serial on bits ten, eleven
// - angle reported as 12-bit unsigned word
// - velocity reported as 12-bit two's complement
// - capture fall copies integrators into holding regs
// - host holds capture, then waits before read
// - capture rise clears monitor min and max
// - conversion keeps running during reads
// - position/velocity pin picks output register source
// - host settles select pin before read strobe
// - device select low enables output transfer
// - read strobe reads register, enables drivers
// - two separate 12-bit holding registers
// - loss flags both low; priority decoding
// - capture rise releases latched fault flags
// - bus floats unless select and read low
// - read fall loads output buffer
`include "rdc_defs.svh"
`default_nettype none
module rdc_device
  import rdc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [11:0] shaft_angle_i,
  input wire logic [11:0] monitor_mag_i,
  output logic [11:0] position_o,
  rdc_link_if.device link
);

  // min starts at the top so the first sample cannot fake a spread
  localparam dev_state_s DEV_RST = '{
    s1: 7'h7f, s2: 7'h7f, s3: 7'h7f, filt: 7'h7f,
    mon_min: `RDC_MON_MIN_RST, degr_n: 1'b1, trk_n: 1'b1, default: '0
  };

  dev_state_s q;
  dev_state_s n;
  logic [6:0] pins;
  logic [6:0] fall;
  logic [6:0] rise;
  logic [11:0] err;
  logic [11:0] err_abs;
  logic [11:0] step;
  logic [11:0] sel_word;
  logic parity;
  logic loss_cond;
  logic over;
  logic mism;
  logic serial;
  logic active;

  // ============================================================
  // pin gathering
  always_comb begin
    pins = '0;
    pins[`RDC_PIN_SAMPLE] = link.sample_n;
    pins[`RDC_PIN_CS] = link.cs_n;
    pins[`RDC_PIN_RD] = link.rd_n;
    pins[`RDC_PIN_PVSEL] = link.pos_vel_select;
    pins[`RDC_PIN_SERSEL] = link.serial_port_select_n;
    pins[`RDC_PIN_SCLK] = link.data_bus[`RDC_BIT_TEN];
    pins[`RDC_PIN_RESET] = link.full_reset_n;
  end

  // ============================================================
  // next-state logic
  always_comb begin
    n = q;
    // three-stage sync; a level counts once stages two and three agree
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < `RDC_PINS; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.filt[i] = q.s2[i];
      end
    end
    fall = q.filt & ~n.filt;
    rise = ~q.filt & n.filt;

    // tracking loop runs every cycle, reads or not
    err = shaft_angle_i - q.pos;
    err_abs = err[11] ? 12'(-err) : err;
    if (err == `RDC_HALF_TURN) begin
      step = 12'h001;
    end else if (err == 12'h000) begin
      // dither around the null so the error never rests
      step = q.dither ? 12'h001 : 12'hfff;
      n.dither = ~q.dither;
    end else begin
      step = err[11] ? 12'hfff : 12'h001;
    end
    n.pos = q.pos + step;
    n.vel = shaft_angle_i - q.prev_angle;
    n.prev_angle = shaft_angle_i;

    // tracking loss with hysteresis, not latched
    if (err_abs > `RDC_TRK_SET) begin
      n.trk_lost = 1'b1;
    end else if (err_abs < `RDC_TRK_CLR) begin
      n.trk_lost = 1'b0;
    end

    // monitor min/max for mismatch; capture rise restarts them
    if (rise[`RDC_PIN_SAMPLE]) begin
      n.mon_min = monitor_mag_i;
      n.mon_max = monitor_mag_i;
    end else begin
      if (monitor_mag_i < q.mon_min) begin
        n.mon_min = monitor_mag_i;
      end
      if (monitor_mag_i > q.mon_max) begin
        n.mon_max = monitor_mag_i;
      end
    end
    // spread of the updated pair: a stale spread must not relatch at a rise
    mism = (12'(n.mon_max - n.mon_min)) > `RDC_DEGR_MISM;
    loss_cond = monitor_mag_i < `RDC_LOSS_MIN;
    over = monitor_mag_i > `RDC_DEGR_MAX;

    // latched faults; a new fault wins over a capture rise
    n.loss_lat = loss_cond | (q.loss_lat & ~rise[`RDC_PIN_SAMPLE]);
    n.degr_lat = mism | (q.degr_lat & ~rise[`RDC_PIN_SAMPLE]);

    // priority decode: loss > degradation > tracking
    n.degr_n = ~(n.loss_lat | n.degr_lat | over);
    n.trk_n = ~(n.loss_lat | (n.trk_lost & ~(n.degr_lat | over)));

    // capture fall snapshots both integrators
    if (fall[`RDC_PIN_SAMPLE]) begin
      n.hold_pos = q.pos;
      n.hold_vel = q.vel;
    end

    // separate holding regs, one routed by the select pin
    sel_word = n.filt[`RDC_PIN_PVSEL] ? q.hold_pos : q.hold_vel;
    if (!n.filt[`RDC_PIN_CS]) begin
      n.out_reg = sel_word;
    end
    parity = ~^{sel_word, n.filt[`RDC_PIN_PVSEL], q.degr_n, q.trk_n};

    // read fall loads buffer and serial shifter
    if (fall[`RDC_PIN_RD] && !n.filt[`RDC_PIN_CS]) begin
      n.out_buf = sel_word;
      n.shift = {sel_word, n.filt[`RDC_PIN_PVSEL], q.degr_n, q.trk_n, parity};
    end else if (rise[`RDC_PIN_SCLK] && !n.filt[`RDC_PIN_RD]) begin
      // past bit zero the shifter feeds out zeros
      n.shift = {q.shift[14:0], 1'b0};
    end

    // drivers: parallel or serial, never forced by faults
    serial = ~n.filt[`RDC_PIN_SERSEL];
    active = ~n.filt[`RDC_PIN_CS] & ~n.filt[`RDC_PIN_RD];
    if (serial) begin
      n.bus_oe = {active, 11'h000};
      n.bus_q = {n.shift[15], 11'h000};
    end else begin
      n.bus_oe = {12{active}};
      n.bus_q = n.out_buf;
    end

    // full reset from the host restarts tracking state
    if (!n.filt[`RDC_PIN_RESET]) begin
      n.pos = '0;
      n.vel = '0;
      n.loss_lat = 1'b0;
      n.degr_lat = 1'b0;
      n.trk_lost = 1'b0;
      n.degr_n = 1'b1;
      n.trk_n = 1'b1;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      q <= DEV_RST;
    end else begin
      q <= n;
    end
  end

  // ============================================================
  // outputs
  assign link.dev_bus = q.bus_q;
  assign link.dev_bus_oe = q.bus_oe;
  assign link.signal_degraded_flag_n = q.degr_n;
  assign link.tracking_lost_flag_n = q.trk_n;
  assign position_o = q.pos;

endmodule
`default_nettype wire

//--- verilog/rdc_host.sv
// host controller end: apb registers drive capture and read sequences
`include "rdc_defs.svh"
`default_nettype none
module rdc_host
  import rdc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  rdc_link_if.host link
);

  localparam host_state_s HOST_RST = '{
    state: H_IDLE, ctrl: `RDC_CTRL_RST, s1: 3'h7, s2: 3'h7, s3: 3'h7, filt: 3'h7,
    sample_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, pvsel: 1'b1, ser_sel_n: 1'b1, sclk: 1'b1,
    full_reset_n: 1'b1, default: '0
  };

  host_state_s q;
  host_state_s n;
  logic wr;
  logic mapped;
  logic busy;
  logic [31:0] status;

  // ============================================================
  // next-state logic
  always_comb begin
    n = q;
    busy = q.state != H_IDLE;
    mapped = paddr_i == `RDC_CTRL_OFS || paddr_i == `RDC_STATUS_OFS
      || paddr_i == `RDC_DATA_OFS;
    wr = psel_i & penable_i & pwrite_i & mapped;

    // flags and serial data come from another chip: three stages
    n.s1 = {link.data_bus[`RDC_BIT_ELEVEN], link.tracking_lost_flag_n,
      link.signal_degraded_flag_n};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.filt[i] = q.s2[i];
      end
    end

    // any fault marks data invalid; signal loss asks for a restart
    n.fault_seen = ~(n.filt[0] & n.filt[1]) | q.fault_seen;
    n.restart = (~n.filt[0] & ~n.filt[1]) | q.restart;

    status = '0;
    status[`RDC_ST_BUSY] = busy;
    status[`RDC_ST_DEGR_N] = q.filt[0];
    status[`RDC_ST_TRK_N] = q.filt[1];
    status[`RDC_ST_FAULT] = q.fault_seen;
    status[`RDC_ST_RESTART] = q.restart;
    status[`RDC_ST_VALID] = ~q.fault_seen;

    // read data is registered in setup so the answer comes from a flop
    if (psel_i && !penable_i) begin
      unique case (paddr_i)
        `RDC_CTRL_OFS: n.prdata = {28'h0000000, q.ctrl};
        `RDC_STATUS_OFS: n.prdata = status;
        `RDC_DATA_OFS: n.prdata = {16'h0000, q.data};
        default: n.prdata = '0;
      endcase
    end

    // write-one-to-clear sticky bits; a new fault wins
    if (wr && paddr_i == `RDC_STATUS_OFS) begin
      if (pwdata_i[`RDC_ST_FAULT] && n.filt[0] && n.filt[1]) begin
        n.fault_seen = 1'b0;
      end
      if (pwdata_i[`RDC_ST_RESTART] && (n.filt[0] | n.filt[1])) begin
        n.restart = 1'b0;
      end
    end

    n.cnt = (q.cnt != 8'h00) ? 8'(q.cnt - 8'h01) : 8'h00;
    unique case (q.state)
      H_IDLE: begin
        // control writes while busy are dropped to keep pins steady
        if (wr && paddr_i == `RDC_CTRL_OFS) begin
          n.ctrl = {1'b0, pwdata_i[2:1], 1'b0};
          n.pvsel = pwdata_i[`RDC_CTRL_PVSEL];
          n.ser_sel_n = ~pwdata_i[`RDC_CTRL_SERIAL];
          n.sclk_oe = pwdata_i[`RDC_CTRL_SERIAL];
          if (pwdata_i[`RDC_CTRL_RESET]) begin
            n.state = H_RST;
            n.full_reset_n = 1'b0;
            n.cnt = 8'(`RDC_DEV_RST_CYC - 1);
          end else if (pwdata_i[`RDC_CTRL_GO]) begin
            n.state = H_SAMP_LO;
            n.sample_n = 1'b0;
            n.cnt = 8'(`RDC_T1_CYC - 1);
          end
        end
      end
      H_RST: begin
        if (q.cnt == 8'h00) begin
          n.full_reset_n = 1'b1;
          n.state = H_IDLE;
        end
      end
      H_SAMP_LO: begin
        if (q.cnt == 8'h00) begin
          n.sample_n = 1'b1;
          n.state = H_SAMP_HI;
          n.cnt = 8'(`RDC_T2_CYC - 1);
        end
      end
      H_SAMP_HI: begin
        if (q.cnt == 8'h00) begin
          n.state = H_SETUP;
          n.cnt = 8'(`RDC_T4_CYC + `RDC_SYNC_CYC - 1);
        end
      end
      H_SETUP: begin
        if (q.cnt == 8'h00) begin
          n.cs_n = 1'b0;
          n.rd_n = 1'b0;
          n.bits = '0;
          n.state = q.ser_sel_n ? H_WAIT : H_SER_HI;
          n.cnt = q.ser_sel_n ? 8'(`RDC_RD_WAIT_CYC - 1) : 8'(`RDC_SCLK_HALF_CYC - 1);
        end
      end
      H_WAIT: begin
        if (q.cnt == 8'h00) begin
          n.data = {4'h0, link.data_bus};
          n.state = H_RELEASE;
          n.cnt = 8'(`RDC_RD_WAIT_CYC - 1);
          n.cs_n = 1'b1;
          n.rd_n = 1'b1;
        end
      end
      H_SER_HI: begin
        if (q.cnt == 8'h00) begin
          n.sclk = 1'b0;
          n.state = H_SER_LO;
          n.cnt = 8'(`RDC_SCLK_HALF_CYC - 1);
        end
      end
      H_SER_LO: begin
        if (q.cnt == 8'h00) begin
          // sample late in the low phase, msb first
          n.data = {q.data[14:0], q.filt[2]};
          n.sclk = 1'b1;
          n.bits = 5'(q.bits + 5'h01);
          n.cnt = 8'(`RDC_SCLK_HALF_CYC - 1);
          n.state = (q.bits == 5'h0f) ? H_RELEASE : H_SER_HI;
          if (q.bits == 5'h0f) begin
            n.cs_n = 1'b1;
            n.rd_n = 1'b1;
          end
        end
      end
      H_RELEASE: begin
        if (q.cnt == 8'h00) begin
          n.state = H_IDLE;
        end
      end
    endcase
  end

  // ============================================================
  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      q <= HOST_RST;
    end else begin
      q <= n;
    end
  end

  // ============================================================
  // outputs
  assign prdata_o = q.prdata;
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign link.sample_n = q.sample_n;
  assign link.cs_n = q.cs_n;
  assign link.rd_n = q.rd_n;
  assign link.pos_vel_select = q.pvsel;
  assign link.serial_port_select_n = q.ser_sel_n;
  assign link.full_reset_n = q.full_reset_n;
  assign link.sclk_drv = q.sclk;
  assign link.sclk_oe = q.sclk_oe;

endmodule
`default_nettype wire

//--- verilog/rdc_link_if.sv
// pin-level link between the converter and its host controller
`default_nettype none
interface rdc_link_if;
  logic sample_n;
  logic cs_n;
  logic rd_n;
  logic pos_vel_select;
  logic serial_port_select_n;
  logic full_reset_n;
  logic [11:0] dev_bus;
  logic [11:0] dev_bus_oe;
  logic sclk_drv;
  logic sclk_oe;
  logic [11:0] data_bus;
  logic signal_degraded_flag_n;
  logic tracking_lost_flag_n;

  // ============================================================
  // wire resolution: undriven bits float up through a pull-up
  always_comb begin
    data_bus = dev_bus | ~dev_bus_oe;
    if (!dev_bus_oe[10] && sclk_oe) begin
      data_bus[10] = sclk_drv;
    end
  end

  modport device (
    input sample_n, cs_n, rd_n, pos_vel_select, serial_port_select_n, full_reset_n,
    input data_bus,
    output dev_bus, dev_bus_oe, signal_degraded_flag_n, tracking_lost_flag_n
  );
  modport host (
    output sample_n, cs_n, rd_n, pos_vel_select, serial_port_select_n, full_reset_n,
    output sclk_drv, sclk_oe,
    input data_bus, signal_degraded_flag_n, tracking_lost_flag_n
  );
endinterface
`default_nettype wire

//--- verilog/rdc_pkg.sv
// types shared by both ends of the resolver readout link
`default_nettype none
package rdc_pkg;
  typedef enum logic [3:0] {
    H_IDLE, H_RST, H_SAMP_LO, H_SAMP_HI, H_SETUP, H_WAIT, H_SER_LO, H_SER_HI, H_RELEASE
  } host_state_e;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] filt;
    logic [11:0] pos;
    logic [11:0] vel;
    logic [11:0] prev_angle;
    logic [11:0] hold_pos;
    logic [11:0] hold_vel;
    logic [11:0] out_reg;
    logic [11:0] out_buf;
    logic [11:0] mon_min;
    logic [11:0] mon_max;
    logic [15:0] shift;
    logic dither;
    logic trk_lost;
    logic loss_lat;
    logic degr_lat;
    logic [11:0] bus_q;
    logic [11:0] bus_oe;
    logic degr_n;
    logic trk_n;
  } dev_state_s;

  typedef struct packed {
    host_state_e state;
    logic [7:0] cnt;
    logic [4:0] bits;
    logic [3:0] ctrl;
    logic fault_seen;
    logic restart;
    logic [15:0] data;
    logic [31:0] prdata;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    logic sample_n;
    logic cs_n;
    logic rd_n;
    logic pvsel;
    logic ser_sel_n;
    logic sclk;
    logic sclk_oe;
    logic full_reset_n;
  } host_state_s;
endpackage
`default_nettype wire
